// *** verilog/vetr_pkg.sv ***
// package for the vlan egress tag rewrite block
// assumes one switch core clock; port tables are indexed by port number
package vetr_pkg;

  localparam int VID_W        = 12;
  localparam int NUM_PORTS    = 8;
  localparam int PORT_W       = 3;
  localparam int CVID_ENTRIES = 16;
  localparam int CIDX_W       = 4;
  localparam int PCP_W        = 3;
  localparam int COS_W        = 3;

  // reset values
  localparam logic [11:0] RST_VID  = 12'h001;
  localparam logic [7:0]  RST_MASK = 8'h00;

  // tag actions on the egress frame
  typedef enum logic [3:0] {
    VETR_ACT_KEEP    = 4'h1,
    VETR_ACT_REPLACE = 4'h2,
    VETR_ACT_STRIP   = 4'h4,
    VETR_ACT_PUSH    = 4'h8
  } vetr_act_type;

  // port configuration word (port_vlan_ctrl)
  typedef struct packed {
    logic              svc_tag_secure_en;
    logic              cust_tag_secure_en;
    logic              svc_passthrough;
    logic              tag_passthrough_mode;
    logic              stag_en;
    logic              cos_from_stag;
    logic [VID_W-1:0]  svc_default_vid;
    logic [VID_W-1:0]  port_default_vid;
  } vetr_port_cfg_type;

  // customer vlan membership entry
  typedef struct packed {
    logic [VID_W-1:0]     vid;
    logic [NUM_PORTS-1:0] port_members;
    logic [NUM_PORTS-1:0] tag_members;
    logic                 reserved;
  } vetr_cvlan_type;

  // classified frame from ingress
  typedef struct packed {
    logic [PORT_W-1:0] in_port;
    logic [PORT_W-1:0] eg_port;
    logic              has_stag;
    logic              has_ctag;
    logic [VID_W-1:0]  svid;
    logic [PCP_W-1:0]  spcp;
    logic              sdei;
    logic [VID_W-1:0]  cvid;
    logic [PCP_W-1:0]  cpcp;
    logic              alt_svid_en;
    logic [VID_W-1:0]  alt_svid;
    logic              alt_cvid_en;
    logic [VID_W-1:0]  alt_cvid;
    logic              pmap_mux;
    logic [NUM_PORTS-1:0] pmap;
    logic              cust_ignore;
  } vetr_frame_type;

  // egress decision
  typedef struct packed {
    logic [VID_W-1:0]  svid;
    logic [VID_W-1:0]  cvid;
    logic [VID_W-1:0]  group_vid;
    logic [CIDX_W-1:0] group_idx;
    logic              group_hit;
    logic [NUM_PORTS-1:0] svc_members;
    logic              cust_member;
    logic              svc_tag_out;
    vetr_act_type      cust_act;
    logic [1:0]        tag_delta_sel;
    logic [COS_W-1:0]  cos;
    logic [PCP_W-1:0]  out_cpcp;
    logic [PCP_W-1:0]  out_spcp;
    logic              out_dei;
  } vetr_result_type;

endpackage

// *** verilog/vetr_top.sv ***
// vlan egress tag rewrite: port config, customer vlan table, egress decision
// assumes classifier and frame editor run on clk_sys with valid/ready handshakes
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Function
// - secure mode associates every frame of a port with its default group
// - secure, egress port and tag member: replace tag, count unchanged
// - secure, port member only: strip original tag, count minus one
// - secure mode acts on service and customer tag, each with its own enable
// - passthrough, port and tag member: push default tag, count plus one
// - passthrough, port member only: send frame unmodified
// - customer table holds a reserved flag per group
// - reserved customer tag with tag member egress: overwrite vid with default
// - reserved replacement on customer tags only, selected per group
// - membership checked against the translated egress group
// - default service vid when untagged, passthrough or secure
// - received service vid kept otherwise
// - alternative service vid from flow action wins
// - default customer vid when untagged, passthrough, secure or reserved
// - received customer vid kept otherwise
// - alternative customer vid from flow action wins unless customer tag is ignored
// - cos from service pcp or customer pcp
// - pcp regenerated from the assigned cos; dei copied from service dei when cos taken from it
// - per port default vid; untagged frames join the default group
// - single tag uses outer customer tag; double tag uses both
// - flow port bitmap used as service members when mux control set
module vetr_top
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic [7:0]                 cfg_addr,
  input  wire logic [31:0]                cfg_wdata,
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_rd,
  output logic [31:0]                     cfg_rdata,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire vetr_pkg::vetr_frame_type   in_frame,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output vetr_pkg::vetr_result_type       out_result
);

  // register map: 0x00..0x1c port cfg lo, 0x20..0x3c port cfg hi
  // 0x40+4*i cvlan vid/reserved, 0x80+4*i members, 0xc0 status
  localparam logic [7:0] OFF_PCFG_LO = 8'h00;
  localparam logic [7:0] OFF_PCFG_HI = 8'h20;
  localparam logic [7:0] OFF_CVID    = 8'h40;
  localparam logic [7:0] OFF_CMEM    = 8'h80;
  localparam logic [7:0] OFF_STAT    = 8'hc0;

  vetr_pkg::vetr_port_cfg_type port_vlan_ctrl_ff [vetr_pkg::NUM_PORTS];
  vetr_pkg::vetr_port_cfg_type nxt_port_vlan_ctrl [vetr_pkg::NUM_PORTS];
  vetr_pkg::vetr_cvlan_type    cvlan_ff [vetr_pkg::CVID_ENTRIES];
  vetr_pkg::vetr_cvlan_type    nxt_cvlan [vetr_pkg::CVID_ENTRIES];
  logic [31:0]                 rdata_ff;
  logic [31:0]                 nxt_rdata;
  logic                        valid_ff;
  logic                        nxt_valid;
  vetr_pkg::vetr_result_type   result_ff;
  vetr_pkg::vetr_result_type   nxt_result;
  logic [15:0]                 frame_cnt_ff;
  logic [15:0]                 nxt_frame_cnt;

  // lookup of customer vid in the membership table
  function automatic logic [vetr_pkg::CIDX_W:0] cvlan_find(
    input vetr_pkg::vetr_cvlan_type tbl [vetr_pkg::CVID_ENTRIES],
    input logic [vetr_pkg::VID_W-1:0] vid
  );
    logic [vetr_pkg::CIDX_W:0] res;
    res = '0;
    for (int i = vetr_pkg::CVID_ENTRIES - 1; i >= 0; i--)
    begin
      if (tbl[i].vid == vid)
      begin
        res = {1'b1, i[vetr_pkg::CIDX_W-1:0]};
      end
    end
    return res;
  endfunction

  // configuration registers
  always_comb
  begin
    logic [2:0] pi;
    logic [3:0] ci;
    pi = cfg_addr[4:2];
    ci = cfg_addr[5:2];
    nxt_port_vlan_ctrl = port_vlan_ctrl_ff;
    nxt_cvlan = cvlan_ff;
    nxt_rdata = 32'h0000_0000;
    if (cfg_wr)
    begin
      if (cfg_addr[7:5] == OFF_PCFG_LO[7:5])
      begin
        nxt_port_vlan_ctrl[pi].port_default_vid = cfg_wdata[11:0];
        nxt_port_vlan_ctrl[pi].svc_default_vid = cfg_wdata[27:16];
      end
      else if (cfg_addr[7:5] == OFF_PCFG_HI[7:5])
      begin
        nxt_port_vlan_ctrl[pi].svc_tag_secure_en = cfg_wdata[0];
        nxt_port_vlan_ctrl[pi].cust_tag_secure_en = cfg_wdata[1];
        nxt_port_vlan_ctrl[pi].svc_passthrough = cfg_wdata[2];
        nxt_port_vlan_ctrl[pi].tag_passthrough_mode = cfg_wdata[3];
        nxt_port_vlan_ctrl[pi].stag_en = cfg_wdata[4];
        nxt_port_vlan_ctrl[pi].cos_from_stag = cfg_wdata[5];
      end
      else if (cfg_addr[7:6] == OFF_CVID[7:6])
      begin
        nxt_cvlan[ci].vid = cfg_wdata[11:0];
        nxt_cvlan[ci].reserved = cfg_wdata[16];
      end
      else if (cfg_addr[7:6] == OFF_CMEM[7:6])
      begin
        nxt_cvlan[ci].port_members = cfg_wdata[7:0];
        nxt_cvlan[ci].tag_members = cfg_wdata[15:8];
      end
    end
    if (cfg_rd)
    begin
      if (cfg_addr[7:5] == OFF_PCFG_LO[7:5])
      begin
        nxt_rdata = {4'h0, port_vlan_ctrl_ff[pi].svc_default_vid,
                     4'h0, port_vlan_ctrl_ff[pi].port_default_vid};
      end
      else if (cfg_addr[7:5] == OFF_PCFG_HI[7:5])
      begin
        nxt_rdata = {26'h000_0000, port_vlan_ctrl_ff[pi].cos_from_stag,
                     port_vlan_ctrl_ff[pi].stag_en,
                     port_vlan_ctrl_ff[pi].tag_passthrough_mode,
                     port_vlan_ctrl_ff[pi].svc_passthrough,
                     port_vlan_ctrl_ff[pi].cust_tag_secure_en,
                     port_vlan_ctrl_ff[pi].svc_tag_secure_en};
      end
      else if (cfg_addr[7:6] == OFF_CVID[7:6])
      begin
        nxt_rdata = {15'h0000, cvlan_ff[ci].reserved, 4'h0, cvlan_ff[ci].vid};
      end
      else if (cfg_addr[7:6] == OFF_CMEM[7:6] && cfg_addr != OFF_STAT)
      begin
        nxt_rdata = {16'h0000, cvlan_ff[ci].tag_members, cvlan_ff[ci].port_members};
      end
      if (cfg_addr == OFF_STAT)
      begin
        nxt_rdata = {15'h0000, valid_ff, frame_cnt_ff};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < vetr_pkg::NUM_PORTS; i++)
      begin
        port_vlan_ctrl_ff[i] <= '{default: '0, port_default_vid: vetr_pkg::RST_VID,
                                  svc_default_vid: vetr_pkg::RST_VID};
      end
      for (int i = 0; i < vetr_pkg::CVID_ENTRIES; i++)
      begin
        cvlan_ff[i] <= '0;
      end
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      port_vlan_ctrl_ff <= nxt_port_vlan_ctrl;
      cvlan_ff <= nxt_cvlan;
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign in_ready = !valid_ff || out_ready;
  assign out_valid = valid_ff;
  assign out_result = result_ff;

  // egress decision
  always_comb
  begin
    vetr_pkg::vetr_port_cfg_type pc;
    vetr_pkg::vetr_port_cfg_type ec;
    logic [vetr_pkg::CIDX_W:0]   rx_hit;
    logic [vetr_pkg::CIDX_W:0]   eg_hit;
    logic                        rx_reserved;
    logic                        ctag_seen;
    logic                        stag_seen;
    logic                        port_mem;
    logic                        tag_mem;
    logic [vetr_pkg::VID_W-1:0]  cv;
    pc = port_vlan_ctrl_ff[in_frame.in_port];
    ec = port_vlan_ctrl_ff[in_frame.eg_port];
    eg_hit = '0;
    port_mem = 1'b0;
    tag_mem = 1'b0;
    cv = '0;
    ctag_seen = in_frame.has_ctag && !in_frame.cust_ignore;
    stag_seen = in_frame.has_stag;
    rx_hit = cvlan_find(cvlan_ff, in_frame.cvid);
    rx_reserved = ctag_seen && rx_hit[vetr_pkg::CIDX_W] &&
                  cvlan_ff[rx_hit[vetr_pkg::CIDX_W-1:0]].reserved;
    nxt_result = result_ff;
    nxt_valid = valid_ff && !out_ready;
    nxt_frame_cnt = frame_cnt_ff;
    if (in_valid && in_ready)
    begin
      nxt_valid = 1'b1;
      nxt_frame_cnt = frame_cnt_ff + 16'h0001;
      if (!stag_seen || pc.svc_passthrough || pc.svc_tag_secure_en)
        nxt_result.svid = pc.svc_default_vid;
      else
        nxt_result.svid = in_frame.svid;
      if (in_frame.alt_svid_en)
        nxt_result.svid = in_frame.alt_svid;
      if (!ctag_seen || pc.tag_passthrough_mode || pc.cust_tag_secure_en || rx_reserved)
        cv = pc.port_default_vid;
      else
        // received customer vid; outer customer tag
        cv = in_frame.cvid;
      if (in_frame.alt_cvid_en)
        cv = in_frame.alt_cvid;
      if (in_frame.cust_ignore)
        cv = in_frame.cvid;
      nxt_result.cvid = cv;
      eg_hit = cvlan_find(cvlan_ff, cv);
      nxt_result.group_vid = cv;
      nxt_result.group_hit = eg_hit[vetr_pkg::CIDX_W];
      nxt_result.group_idx = eg_hit[vetr_pkg::CIDX_W-1:0];
      port_mem = eg_hit[vetr_pkg::CIDX_W] &&
                 cvlan_ff[eg_hit[vetr_pkg::CIDX_W-1:0]].port_members[in_frame.eg_port];
      tag_mem = eg_hit[vetr_pkg::CIDX_W] &&
                cvlan_ff[eg_hit[vetr_pkg::CIDX_W-1:0]].tag_members[in_frame.eg_port];
      nxt_result.cust_member = port_mem || in_frame.cust_ignore;
      if (in_frame.pmap_mux)
        nxt_result.svc_members = in_frame.pmap;
      else
        nxt_result.svc_members = {vetr_pkg::NUM_PORTS{1'b1}};
      // double tag: service tag on stag ports
      nxt_result.svc_tag_out = ec.stag_en;
      nxt_result.tag_delta_sel = 2'b01;
      nxt_result.cust_act = vetr_pkg::VETR_ACT_KEEP;
      if (in_frame.cust_ignore)
        nxt_result.cust_act = vetr_pkg::VETR_ACT_KEEP;
      else if (pc.cust_tag_secure_en && ctag_seen)
      begin
        if (tag_mem)
          nxt_result.cust_act = vetr_pkg::VETR_ACT_REPLACE;
        else
        begin
          nxt_result.cust_act = vetr_pkg::VETR_ACT_STRIP;
          nxt_result.tag_delta_sel = 2'b00;
        end
      end
      else if (pc.tag_passthrough_mode && ctag_seen)
      begin
        if (tag_mem)
        begin
          nxt_result.cust_act = vetr_pkg::VETR_ACT_PUSH;
          nxt_result.tag_delta_sel = 2'b10;
        end
        else
          nxt_result.cust_act = vetr_pkg::VETR_ACT_KEEP;
      end
      else if (rx_reserved && tag_mem)
        nxt_result.cust_act = vetr_pkg::VETR_ACT_REPLACE;
      else if (!ctag_seen && tag_mem)
      begin
        nxt_result.cust_act = vetr_pkg::VETR_ACT_PUSH;
        nxt_result.tag_delta_sel = 2'b10;
      end
      else if (ctag_seen && !tag_mem)
      begin
        nxt_result.cust_act = vetr_pkg::VETR_ACT_STRIP;
        nxt_result.tag_delta_sel = 2'b00;
      end
      else if (ctag_seen && cv != in_frame.cvid)
        nxt_result.cust_act = vetr_pkg::VETR_ACT_REPLACE;
      if (stag_seen && pc.cos_from_stag)
        nxt_result.cos = in_frame.spcp;
      else if (ctag_seen)
        nxt_result.cos = in_frame.cpcp;
      else
        nxt_result.cos = '0;
      nxt_result.out_cpcp = nxt_result.cos;
      nxt_result.out_spcp = nxt_result.cos;
      nxt_result.out_dei = stag_seen && pc.cos_from_stag && in_frame.sdei;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      valid_ff <= 1'b0;
      result_ff <= '0;
      frame_cnt_ff <= 16'h0000;
    end
    else
    begin
      valid_ff <= nxt_valid;
      result_ff <= nxt_result;
      frame_cnt_ff <= nxt_frame_cnt;
    end
  end

endmodule

`default_nettype wire

// *** test/vetr_chk.sv ***
// checker on the top ports of the vlan egress tag rewrite
// assumes one clock clk_sys and async active high rst
`timescale 1ns/10ps
`default_nettype none
module vetr_chk
(
  input wire logic                      clk_sys,
  input wire logic                      rst,
  input wire logic                      in_valid,
  input wire logic                      in_ready,
  input wire vetr_pkg::vetr_frame_type  in_frame,
  input wire logic                      out_valid,
  input wire logic                      out_ready,
  input wire vetr_pkg::vetr_result_type out_result
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_take;
    in_valid && in_ready;
  endsequence
  sequence s_held;
    out_valid && !out_ready;
  endsequence
  property p_answer;
    s_take |=> out_valid;
  endproperty
  property p_hold;
    s_held |=> out_valid && $stable(out_result);
  endproperty
  property p_alt_svid;
    s_take ##0 in_frame.alt_svid_en |=> out_result.svid == $past(in_frame.alt_svid);
  endproperty
  property p_alt_cvid;
    s_take ##0 (in_frame.alt_cvid_en && !in_frame.cust_ignore) |=> out_result.cvid == $past(in_frame.alt_cvid);
  endproperty
  property p_ignore;
    s_take ##0 in_frame.cust_ignore |=> out_result.cust_act == vetr_pkg::VETR_ACT_KEEP && out_result.cust_member
      && out_result.cvid == $past(in_frame.cvid);
  endproperty
  property p_pmap;
    s_take ##0 in_frame.pmap_mux |=> out_result.svc_members == $past(in_frame.pmap);
  endproperty
  property p_pcp;
    out_valid |-> out_result.out_cpcp == out_result.cos;
  endproperty
  property p_cos_cust;
    s_take ##0 (!in_frame.has_stag && in_frame.has_ctag && !in_frame.cust_ignore)
      |=> out_result.cos == $past(in_frame.cpcp);
  endproperty
  a_answer: assert property (p_answer) else $error("no result after accepted frame");
  a_hold: assert property (p_hold) else $error("result changed while stalled");
  a_alt_svid: assert property (p_alt_svid) else $error("alternative service vid not used");
  a_alt_cvid: assert property (p_alt_cvid) else $error("alternative customer vid not used");
  a_ignore: assert property (p_ignore) else $error("ignored customer tag was touched");
  a_pmap: assert property (p_pmap) else $error("flow port bitmap not used");
  a_pcp: assert property (p_pcp) else $error("customer pcp not taken from cos");
  a_cos_cust: assert property (p_cos_cust) else $error("cos not from customer pcp");
endmodule
bind vetr_top vetr_chk vetr_chk_i (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
  .in_frame(in_frame), .out_valid(out_valid), .out_ready(out_ready), .out_result(out_result));
`default_nettype wire

// *** test/vetr_far_model.sv ***
// far side: classifier handing frames in, frame editor taking results
// assumes design samples on the clk_sys rising edge
`timescale 1ns/10ps
`default_nettype none
module vetr_far_model
(
  input  wire logic                      clk_sys,
  input  wire logic                      in_ready,
  input  wire logic                      out_valid,
  input  wire vetr_pkg::vetr_result_type out_result,
  output logic                           in_valid,
  output vetr_pkg::vetr_frame_type       in_frame,
  output logic                           out_ready
);
  initial
  begin
    in_valid = 1'b0;
    in_frame = '0;
    out_ready = 1'b1;
  end
  // one descriptor in, one result out; editor may stall
  task automatic xfer(input vetr_pkg::vetr_frame_type f, input int stall, output vetr_pkg::vetr_result_type r);
    int k;
    @(posedge clk_sys);
    in_valid <= 1'b1;
    in_frame <= f;
    out_ready <= (stall == 0);
    @(posedge clk_sys);
    for (k = 0; k < 20 && !in_ready; k++)
      @(posedge clk_sys);
    in_valid <= 1'b0;
    in_frame <= ~f;
    @(posedge clk_sys);
    if (stall > 0)
    begin
      repeat (stall) @(posedge clk_sys);
      out_ready <= 1'b1;
      @(posedge clk_sys);
    end
    r = out_result;
  endtask
endmodule
`default_nettype wire

// *** test/vetr_top_test.sv ***
// self-checking bench for the vlan egress tag rewrite
// assumes vetr_top, vetr_chk bind and vetr_far_model compiled before
`timescale 1ns/10ps
`default_nettype none
module vetr_top_test;
  logic                      clk_sys = 1'b0;
  logic                      rst = 1'b1;
  logic [7:0]                cfg_addr = 8'h00;
  logic [31:0]               cfg_wdata = 32'h0;
  logic                      cfg_wr = 1'b0;
  logic                      cfg_rd = 1'b0;
  logic [31:0]               cfg_rdata;
  logic                      in_valid;
  logic                      in_ready;
  logic                      out_valid;
  logic                      out_ready;
  vetr_pkg::vetr_frame_type  in_frame;
  vetr_pkg::vetr_frame_type  f;
  vetr_pkg::vetr_result_type out_result;
  vetr_pkg::vetr_result_type res;
  logic [31:0]               d;
  int                        n_mismatch = 0;
  int                        check_count = 0;
  int                        nf = 0;
  always #5 clk_sys = ~clk_sys;
  vetr_top vetr_top_i (.clk_sys(clk_sys), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .in_valid(in_valid), .in_ready(in_ready),
    .in_frame(in_frame), .out_valid(out_valid), .out_ready(out_ready), .out_result(out_result));
  vetr_far_model vetr_far_model_i (.clk_sys(clk_sys), .in_ready(in_ready), .out_valid(out_valid),
    .out_result(out_result), .in_valid(in_valid), .in_frame(in_frame), .out_ready(out_ready));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= v;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    v = cfg_rdata;
  endtask
  function automatic vetr_pkg::vetr_frame_type mk(input logic [2:0] ip, input logic [2:0] ep, input logic st,
    input logic ct, input logic [11:0] sv, input logic [11:0] cv);
    vetr_pkg::vetr_frame_type t;
    t = '0;
    t.in_port = ip;
    t.eg_port = ep;
    t.has_stag = st;
    t.has_ctag = ct;
    t.svid = sv;
    t.cvid = cv;
    return t;
  endfunction
  task automatic run(input vetr_pkg::vetr_frame_type fr, input int stall);
    vetr_far_model_i.xfer(fr, stall, res);
    nf++;
  endtask
  task automatic ck(input vetr_pkg::vetr_frame_type fr, input logic [11:0] cv, input vetr_pkg::vetr_act_type act,
    input logic [1:0] dl);
    run(fr, 0);
    check("cvid", 32'(res.cvid), 32'(cv));
    check("cust_act", 32'(res.cust_act), 32'(act));
    check("tag_delta", 32'(res.tag_delta_sel), 32'(dl));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h00, d);
    check("port_default_vid reset", d, 32'h0001_0001);
    rd(8'hfc, d);
    check("unmapped", d, 32'h0);
    for (int p = 0; p < 6; p++)
      wr(8'(4 * p), 32'h012d_000a);
    wr(8'h24, 32'h02);
    wr(8'h28, 32'h08);
    wr(8'h30, 32'h30);
    wr(8'h34, 32'h01);
    wr(8'h40, 32'h00a);
    wr(8'h80, 32'h2123);
    wr(8'h44, 32'h00b);
    wr(8'h84, 32'h002c);
    wr(8'h48, 32'h1_000c);
    wr(8'h88, 32'h2030);
    rd(8'h48, d);
    check("reserved flag", d, 32'h0001_000c);
    ck(mk(0, 5, 0, 0, 12'h0, 12'h0), 12'h00a, vetr_pkg::VETR_ACT_PUSH, 2'd2);
    check("svid untagged", 32'(res.svid), 32'h12d);
    ck(mk(0, 2, 1, 1, 12'h055, 12'h00b), 12'h00b, vetr_pkg::VETR_ACT_STRIP, 2'd0);
    check("svid kept", 32'(res.svid), 32'h055);
    ck(mk(1, 5, 0, 1, 12'h0, 12'h00b), 12'h00a, vetr_pkg::VETR_ACT_REPLACE, 2'd1);
    ck(mk(1, 1, 1, 1, 12'h0, 12'h00b), 12'h00a, vetr_pkg::VETR_ACT_STRIP, 2'd0);
    ck(mk(2, 5, 0, 1, 12'h0, 12'h00b), 12'h00a, vetr_pkg::VETR_ACT_PUSH, 2'd2);
    ck(mk(2, 1, 0, 1, 12'h0, 12'h00b), 12'h00a, vetr_pkg::VETR_ACT_KEEP, 2'd1);
    ck(mk(3, 5, 0, 1, 12'h0, 12'h00c), 12'h00a, vetr_pkg::VETR_ACT_REPLACE, 2'd1);
    run(mk(5, 5, 1, 1, 12'h077, 12'h00a), 0);
    check("svid secure", 32'(res.svid), 32'h12d);
    f = mk(4, 5, 1, 1, 12'h055, 12'h00a);
    f.spcp = 3'h5;
    f.cpcp = 3'h2;
    run(f, 2);
    check("cos stag", 32'(res.cos), 32'h5);
    check("spcp", 32'(res.out_spcp), 32'h5);
    f = mk(0, 5, 0, 1, 12'h0, 12'h00a);
    f.cpcp = 3'h3;
    run(f, 0);
    check("cos ctag", 32'(res.cos), 32'h3);
    f = mk(0, 3, 1, 1, 12'h055, 12'h00a);
    f.alt_svid_en = 1'b1;
    f.alt_svid = 12'h123;
    f.alt_cvid_en = 1'b1;
    f.alt_cvid = 12'h00b;
    f.pmap_mux = 1'b1;
    f.pmap = 8'h5a;
    run(f, 0);
    check("alt svid", 32'(res.svid), 32'h123);
    check("alt cvid", 32'(res.cvid), 32'h00b);
    check("translated member", 32'(res.cust_member), 32'h1);
    check("svc members", 32'(res.svc_members), 32'h5a);
    f = mk(0, 3, 0, 1, 12'h0, 12'h00c);
    f.cust_ignore = 1'b1;
    run(f, 3);
    check("ignored cvid", 32'(res.cvid), 32'h00c);
    check("ignored member", 32'(res.cust_member), 32'h1);
    rd(8'hc0, d);
    check("frame count", 32'(d[15:0]), 32'(nf));
    tally_and_finish();
  end
endmodule
`default_nettype wire
